// *** rtl/uvp_host.sv ***
// host controller that reads and programs a 4096 x 8 uv eprom through its pins
// assumes pin inputs synchronous to clk_sys and an external 21 V switch on vpp_en
// assumes clk_en gates every register, so a low level stretches every timed phase
`timescale 1ns/1ps

// What this block does
// - the device drives data only while chip select and output gate are both low
// - program mode is entered by raising the gate pin from low to 21 V, or from high for a request in the first cycle after reset
// - with 21 V applied, data and address are set up, then one 10 ms low pulse on select
// - the programming pulse on chip select never lasts beyond 11 ms; the guard counts only cycles with clk_en high, so a low clk_en stretches it
// - each location gets its own pulse and locations may come in any order
// - verify drives select and gate low and reads back the stored byte
// - a device with select high under 21 V is not programmed and floats its lines
// - several devices may be programmed in parallel with the same sequence
module uvp_host (
   input wire logic clk_sys, // system clock
   input wire logic resetn, // async reset, active low
   input wire logic clk_en, // freezes all state when low
   input wire logic req_valid, // request strobe
   input wire uvp_pkg::uvp_req_t req, // address, data, program flag
   output logic req_ready, // idle and able to take a request
   output logic rsp_valid, // one-cycle answer strobe
   output uvp_pkg::uvp_rsp_t rsp, // read data and verify result
   output logic [uvp_pkg::ADDR_W-1:0] word_select_lines, // address pins
   output logic chip_sel_n, // chip select pin, active low
   output logic gate_n, // output gate logic level, active low
   output logic vpp_en, // switches the gate pin to 21 V
   output logic [uvp_pkg::DATA_W-1:0] byte_lines_o, // data pins, driven value
   output logic byte_lines_oe, // data pins driven by host
   input wire logic [uvp_pkg::DATA_W-1:0] byte_lines_i // data pins, sampled value
);

   typedef struct packed {
      uvp_pkg::uvp_state_t st;
      logic [uvp_pkg::CNT_W-1:0] cnt;
      logic prog;
      logic ready;
      logic rsp_valid;
      uvp_pkg::uvp_rsp_t rsp;
      uvp_pkg::uvp_pins_t pins;
      logic [uvp_pkg::CNT_W-1:0] guard;
   } uvp_host_state_t;

   uvp_host_state_t r;
   uvp_host_state_t next_r;

   // ****************************************
   // phase timer decode
   // ****************************************
   // one shared counter times every phase, so only its end point moves with the state
   logic [uvp_pkg::CNT_W-1:0] last_tick;
   logic phase_end;
   logic pulse_cap;

   always_comb begin
      last_tick = '0;
      unique case (r.st)
         uvp_pkg::UVP_SETUP,
         uvp_pkg::UVP_HOLD,
         uvp_pkg::UVP_DONE: begin
            last_tick = uvp_pkg::CNT_W'(uvp_pkg::SETUP_CYC - 1);
         end
         uvp_pkg::UVP_PULSE: begin
            last_tick = uvp_pkg::CNT_W'(uvp_pkg::PULSE_CYC - 1);
         end
         uvp_pkg::UVP_READ: begin
            last_tick = uvp_pkg::CNT_W'(uvp_pkg::ACCESS_CYC - 1);
         end
         default: begin
            last_tick = '0;
         end
      endcase
   end

   assign phase_end = (r.cnt == last_tick);
   // second, independent limit on a select pulse under 21 V
   assign pulse_cap = (r.guard == uvp_pkg::CNT_W'(uvp_pkg::PULSE_MAX_CYC - 1));

   // ****************************************
   // sequencer
   // ****************************************
   always_comb begin
      next_r = r;
      next_r.rsp_valid = 1'b0;
      unique case (r.st)
         uvp_pkg::UVP_IDLE: begin
            // standby: select high, gate low, nothing driven
            next_r.pins.chip_sel_n = 1'b1;
            next_r.pins.byte_oe = 1'b0;
            next_r.pins.gate_n = 1'b0;
            if (req_valid) begin
               next_r.ready = 1'b0;
               next_r.prog = req.prog;
               next_r.pins.word_select_lines = req.addr;
               next_r.pins.byte_out = req.data;
               next_r.cnt = '0;
               if (req.prog) begin
                  next_r.pins.gate_n = 1'b0;
                  next_r.pins.vpp_en = 1'b1;
                  next_r.pins.byte_oe = 1'b1;
                  next_r.st = uvp_pkg::UVP_SETUP;
               end else begin
                  next_r.pins.gate_n = 1'b0;
                  next_r.pins.chip_sel_n = 1'b0;
                  next_r.st = uvp_pkg::UVP_READ;
               end
            end
         end
         uvp_pkg::UVP_SETUP: begin
            // vpp, address and data settle before the pulse
            next_r.cnt = r.cnt + 1'b1;
            if (phase_end) begin
               next_r.cnt = '0;
               next_r.pins.chip_sel_n = 1'b0;
               next_r.st = uvp_pkg::UVP_PULSE;
            end
         end
         uvp_pkg::UVP_PULSE: begin
            // address and data held constant for the whole pulse
            next_r.cnt = r.cnt + 1'b1;
            if (phase_end) begin
               next_r.cnt = '0;
               next_r.pins.chip_sel_n = 1'b1;
               next_r.st = uvp_pkg::UVP_HOLD;
            end
         end
         uvp_pkg::UVP_HOLD: begin
            // data hold and vpp recovery, then release data before verify
            next_r.cnt = r.cnt + 1'b1;
            if (phase_end) begin
               next_r.cnt = '0;
               next_r.pins.vpp_en = 1'b0;
               next_r.pins.byte_oe = 1'b0;
               next_r.st = uvp_pkg::UVP_DONE;
            end
         end
         uvp_pkg::UVP_DONE: begin
            // one recovery interval with gate low and select high
            next_r.cnt = r.cnt + 1'b1;
            if (phase_end) begin
               next_r.cnt = '0;
               next_r.pins.chip_sel_n = 1'b0;
               next_r.st = uvp_pkg::UVP_READ;
            end
         end
         uvp_pkg::UVP_READ: begin
            // wait out the slowest access time, then sample
            next_r.cnt = r.cnt + 1'b1;
            if (phase_end) begin
               next_r.cnt = '0;
               // host data is already released here, so the pins show only the eprom
               next_r.rsp.data = byte_lines_i;
               // a bit can only go 1->0, so any readback differing is a failure
               next_r.rsp.mismatch = r.prog && (byte_lines_i != r.pins.byte_out);
               next_r.rsp_valid = 1'b1;
               next_r.pins.chip_sel_n = 1'b1;
               next_r.ready = 1'b1;
               next_r.st = uvp_pkg::UVP_IDLE;
            end
         end
         default: begin
            next_r.st = uvp_pkg::UVP_IDLE;
            next_r.ready = 1'b1;
            next_r.pins.chip_sel_n = 1'b1;
            next_r.pins.vpp_en = 1'b0;
            next_r.pins.byte_oe = 1'b0;
            next_r.pins.gate_n = 1'b0;
            next_r.cnt = '0;
         end
      endcase
      // the guard keeps its own count, so an overlong pulse is cut whatever the state says
      if (r.pins.vpp_en && !r.pins.chip_sel_n) begin
         next_r.guard = r.guard + 1'b1;
      end else begin
         next_r.guard = '0;
      end
      if (pulse_cap) begin
         next_r.pins.chip_sel_n = 1'b1;
      end
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         r.st <= uvp_pkg::UVP_IDLE;
         r.cnt <= '0;
         r.guard <= '0;
         r.prog <= 1'b0;
         r.ready <= 1'b1;
         r.rsp_valid <= 1'b0;
         r.rsp <= '0;
         r.pins.word_select_lines <= '0;
         r.pins.chip_sel_n <= 1'b1;
         r.pins.gate_n <= 1'b1;
         r.pins.vpp_en <= 1'b0;
         r.pins.byte_out <= '0;
         r.pins.byte_oe <= 1'b0;
      end else if (clk_en) begin
         r <= next_r;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   // pins come straight from the state register, so no decode glitch reaches the eprom
   assign req_ready = r.ready;
   assign rsp_valid = r.rsp_valid;
   assign rsp = r.rsp;
   assign word_select_lines = r.pins.word_select_lines;
   assign chip_sel_n = r.pins.chip_sel_n;
   assign gate_n = r.pins.gate_n;
   assign vpp_en = r.pins.vpp_en;
   assign byte_lines_o = r.pins.byte_out;
   assign byte_lines_oe = r.pins.byte_oe;

endmodule : uvp_host

// *** include/uvp_pkg.sv ***
// package for the eprom read/program host controller
// assumes a 200 MHz system clock and an external 21 V switch driven by a logic enable
package uvp_pkg;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned CLK_MHZ = 200;
   // program pulse: nominal 10 ms, never above 11 ms
   localparam int unsigned PULSE_MS = 10;
   localparam int unsigned PULSE_MAX_MS = 11;
   localparam int unsigned PULSE_CYC = PULSE_MS * 1000 * CLK_MHZ;
   localparam int unsigned PULSE_MAX_CYC = PULSE_MAX_MS * 1000 * CLK_MHZ;
   // setup/hold around the pulse and read settle, in us / ns
   localparam int unsigned SETUP_US = 2;
   localparam int unsigned SETUP_CYC = SETUP_US * CLK_MHZ;
   localparam int unsigned ACCESS_NS = 450;
   localparam int unsigned ACCESS_CYC = (ACCESS_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned CNT_W = 22;
   localparam logic [DATA_W-1:0] ERASED = 8'hff;

   typedef enum logic [2:0] {
      UVP_IDLE = 3'b000,
      UVP_SETUP = 3'b001,
      UVP_PULSE = 3'b011,
      UVP_HOLD = 3'b010,
      UVP_READ = 3'b100,
      UVP_DONE = 3'b110
   } uvp_state_t; // gray along idle, setup, pulse, hold, done, read, idle

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic prog;
   } uvp_req_t;

   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic mismatch;
   } uvp_rsp_t;

   typedef struct packed {
      logic [ADDR_W-1:0] word_select_lines;
      logic chip_sel_n;
      logic gate_n;
      logic vpp_en;
      logic [DATA_W-1:0] byte_out;
      logic byte_oe;
   } uvp_pins_t;
endpackage : uvp_pkg

// *** verif/uvp_host_asserts.sv ***
// pin-order checks for the eprom host controller
// assumes bind onto uvp_host and clk_en held high while a read is in flight
`timescale 1ns/1ps
module uvp_host_chk (
   input wire logic clk_sys, // clock
   input wire logic resetn, // reset
   input wire logic req_valid, // strobe
   input wire logic req_ready, // idle
   input wire uvp_pkg::uvp_req_t req, // request
   input wire logic rsp_valid, // answer
   input wire logic [uvp_pkg::ADDR_W-1:0] word_select_lines, // address
   input wire logic chip_sel_n, // select
   input wire logic gate_n, // gate
   input wire logic vpp_en, // 21 V
   input wire logic [uvp_pkg::DATA_W-1:0] byte_lines_o, // data out
   input wire logic byte_lines_oe // data drive
);
   // ************
   // properties
   // ************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   int unsigned cnt;
   wire take = req_valid && req_ready;
   sequence rd_s; (!chip_sel_n && !gate_n && !vpp_en)[*8]; endsequence
   sequence pg_s; (vpp_en && byte_lines_oe && chip_sel_n)[*8]; endsequence
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) cnt <= 0;
      else cnt <= (vpp_en && !chip_sel_n) ? cnt + 1 : 0;
   end
   read_select_a: assert property (take && !req.prog |=> rd_s) else $error("read pins");
   prog_entry_a: assert property (take && req.prog |=> pg_s) else $error("prog entry");
   addr_set_a: assert property (take |=> word_select_lines == $past(req.addr))
      else $error("address");
   pulse_setup_a: assert property (vpp_en && $fell(chip_sel_n) |-> byte_lines_oe &&
      $stable(byte_lines_o) && $stable(word_select_lines)) else $error("setup");
   pulse_max_a: assert property (cnt <= uvp_pkg::PULSE_MAX_CYC) else $error("pulse long");
   pulse_hold_a: assert property (vpp_en && !chip_sel_n |=> $stable(byte_lines_o) &&
      $stable(word_select_lines)) else $error("hold");
   drive_prog_a: assert property (byte_lines_oe |-> vpp_en) else $error("contention");
   read_answer_a: assert property (take && !req.prog |-> ##91 rsp_valid)
      else $error("latency");
endmodule : uvp_host_chk
bind uvp_host uvp_host_chk u_uvp_host_chk (.clk_sys(clk_sys), .resetn(resetn),
   .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
   .word_select_lines(word_select_lines), .chip_sel_n(chip_sel_n), .gate_n(gate_n),
   .vpp_en(vpp_en), .byte_lines_o(byte_lines_o), .byte_lines_oe(byte_lines_oe));

// *** verif/uvp_mem_model.sv ***
// behavioural 4096 x 8 uv eprom seen at its pins
// assumes the gate pin reads 21 V whenever vpp_en is high
`timescale 1ns/1ps
module uvp_mem_model (
   input wire logic [11:0] word_select_lines, // address
   input wire logic chip_sel_n, // select
   input wire logic gate_n, // gate
   input wire logic vpp_en, // 21 V
   input wire logic [7:0] byte_lines_o, // host data
   output logic [7:0] byte_lines_i // pins seen
);
   // *******
   // array
   // *******
   logic [7:0] mem [4096];
   initial foreach (mem[i]) mem[i] = uvp_pkg::ERASED;
   // a cut pulse leaves the cell alone; programming only clears bits
   localparam realtime PULSE_MIN = 9.0e6; // shortest pulse that programs, ns
   logic [11:0] pulse_addr;
   logic [7:0] pulse_data;
   logic pulse_live = 1'b0;
   realtime pulse_start;
   // select high under 21 V never opens a pulse, so that device stays inhibited
   always @(chip_sel_n) begin
      if (!chip_sel_n) begin
         pulse_live = vpp_en;
         pulse_addr = word_select_lines;
         pulse_data = byte_lines_o;
         pulse_start = $realtime;
      end else if (pulse_live) begin
         if ($realtime - pulse_start >= PULSE_MIN) mem[pulse_addr] &= pulse_data;
         pulse_live = 1'b0;
      end
   end
   // floating pins show the inverse so a stale value never passes
   always @* byte_lines_i = (!chip_sel_n && !gate_n && !vpp_en) ? mem[word_select_lines]
      : ~mem[word_select_lines];
endmodule : uvp_mem_model

// *** verif/testbench.sv ***
// self-checking bench for the eprom host controller
// assumes the full-length program pulse, so program is aborted by reset
`timescale 1ns/1ps
module testbench;
   // *******
   // setup
   // *******
   logic clk_sys = 0, resetn = 0, clk_en = 1, req_valid = 0;
   uvp_pkg::uvp_req_t req = '0;
   uvp_pkg::uvp_rsp_t rsp;
   logic req_ready, rsp_valid, cs_n, g_n, vpp, oe;
   logic [11:0] wsl;
   logic [7:0] bo, bi;
   int failures = 0, checks = 0;
   always #2.5 clk_sys = ~clk_sys;
   uvp_host u_uvp_host (.clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en),
      .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
      .rsp(rsp), .word_select_lines(wsl), .chip_sel_n(cs_n), .gate_n(g_n), .vpp_en(vpp),
      .byte_lines_o(bo), .byte_lines_oe(oe), .byte_lines_i(bi));
   uvp_mem_model u_uvp_mem_model (.word_select_lines(wsl), .chip_sel_n(cs_n),
      .gate_n(g_n), .vpp_en(vpp), .byte_lines_o(bo), .byte_lines_i(bi));
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task end_of_test;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : end_of_test
   task do_req(input logic [11:0] a, input logic [7:0] d, input logic p);
      int i;
      @(posedge clk_sys);
      req_valid <= 1'b1;
      req <= '{addr: a, data: d, prog: p};
      @(posedge clk_sys);
      for (i = 0; i < 200 && !req_ready; i++) @(posedge clk_sys);
      if (i == 200) begin failures++; end_of_test(); end
      req_valid <= 1'b0;
   endtask : do_req
   task read_chk(input logic [11:0] a, input logic [7:0] d);
      int i;
      do_req(a, 8'h00, 1'b0);
      for (i = 0; i < 200 && !rsp_valid; i++) @(posedge clk_sys);
      if (i == 200) begin failures++; end_of_test(); end
      check(rsp, {d, 1'b0});
   endtask : read_chk
   task reads;
      u_uvp_mem_model.mem[12'hfff] = 8'h81;
      u_uvp_mem_model.mem[12'h5a5] = 8'h3c;
      read_chk(12'hfff, 8'h81);
      read_chk(12'h5a5, 8'h3c);
      read_chk(12'h010, uvp_pkg::ERASED);
   endtask : reads
   task prog_abort;
      do_req(12'h123, 8'h5a, 1'b1);
      @(posedge clk_sys);
      check({vpp, oe, cs_n, g_n, bo, wsl}, {4'b1110, 8'h5a, 12'h123});
      // ten frozen edges slide the setup interval by ten
      clk_en <= 1'b0;
      repeat (10) @(posedge clk_sys);
      clk_en <= 1'b1;
      repeat (399) @(posedge clk_sys);
      check(cs_n, 1'b1);
      @(posedge clk_sys);
      check({cs_n, wsl, bo}, {1'b0, 12'h123, 8'h5a});
      resetn <= 1'b0;
      repeat (6) @(posedge clk_sys);
      check({cs_n, g_n, vpp, oe}, 4'b1100);
      resetn <= 1'b1;
   endtask : prog_abort
   initial begin
      repeat (6) @(posedge clk_sys);
      check({cs_n, vpp, oe, req_ready}, 4'b1001);
      resetn <= 1'b1;
      reads();
      prog_abort();
      read_chk(12'h000, uvp_pkg::ERASED);
      end_of_test();
   end
endmodule : testbench
